// File: logic/fls_decoder.sv
// five-level start-stop receiver, case decoder and stage sequencer
`include "fls_regs.svh"

// ********************************************************************
// code buffer between selector and code bar stage
// ********************************************************************
module fls_fifo #(
    parameter int WIDTH = `FLS_CODE_W,
    parameter int DEPTH = `FLS_FIFO_DEPTH
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    // honest flags straight from the fill count
    assign in_ready_out = (cnt_reg != DEPTH[AW:0]);
    assign out_valid_out = (cnt_reg != '0);
    assign out_data_out = mem_reg[rd_reg];

    // pointers and count
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else if (ce_in) begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (pop) rd_reg <= rd_reg + 1'b1;
            if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
            else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
        end
    end

    // storage, no reset needed on data
    always_ff @(posedge clk_in) begin
        if (ce_in && push) mem_reg[wr_reg] <= in_data_in;
    end
endmodule : fls_fifo

// ********************************************************************
// top: decoder and sequencer
// ********************************************************************
// Operation
// - five pulses give thirty-two raw codes
// - all-marking code selects letters case
// - pulses 1,2,4,5 marking select figures
// - other codes mean two things, by case
// - spacing start pulse triggers pulse sampling
// - adjustable offset from start to samples
// - code bar starts after five pulses latched
// - stages run selector to line feed order
// - space suppressible, print always runs; line feed conditional
// - functions drive outputs; return resets column
// - line feed advances one or two lines
// - function codes print a blank position
// - graphic advances column by one, except at line end
// - no spacing on functions or line end
// - space, feed third turn; others full
// - shaft runs; sequences start on signal
// - finished stage waits idle until retriggered
// - stop pulse 1.42 or 1.0 unit
// - current is marking, none is spacing
module fls_decoder #(
    parameter int REV_CYCLES = 12000
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    // signal line, 1 = current flowing
    input wire logic line_in,
    // timing and configuration
    input wire logic [`FLS_TMR_W-1:0] unit_len_in,
    input wire logic [`FLS_TMR_W-1:0] sample_ofs_in,
    input wire logic double_lf_in,
    input wire logic err_clear_in,
    // stage and decode outputs
    output fls_pkg::fls_seq_state_t stage_out,
    output logic [`FLS_CODE_W-1:0] code_bar_out,
    output logic figs_case_out,
    output logic [`FLS_FN_W-1:0] func_out,
    output logic print_out,
    output logic blank_out,
    output logic [`FLS_CODE_W:0] char_out,
    output logic space_step_out,
    output logic lf_step_out,
    output logic [`FLS_COL_W-1:0] column_out,
    // status
    output logic frame_err_out,
    output logic overrun_out
);
    import fls_pkg::*;

    localparam int THIRD_CYCLES = REV_CYCLES / 3;
    localparam logic [`FLS_TMR_W-1:0] REV_LAST =
        `FLS_TMR_W'(REV_CYCLES - 1);
    localparam logic [`FLS_TMR_W-1:0] THIRD_LAST =
        `FLS_TMR_W'(THIRD_CYCLES - 1);

    // non-typing function codes; space is not one, it still spaces
    function automatic logic fls_is_func(input logic [4:0] c);
        fls_is_func = (c == `FLS_CODE_LETTERS) ||
            (c == `FLS_CODE_FIGURES) || (c == `FLS_CODE_CR) ||
            (c == `FLS_CODE_LF) || (c == `FLS_CODE_BLANK);
    endfunction : fls_is_func

    // ****************************************************************
    // reset release and line synchroniser
    // ****************************************************************
    logic [1:0] rst_sync_reg;
    wire rst_n = rst_sync_reg[1];

    // reset asserts at once, releases after two edges
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) rst_sync_reg <= 2'b00;
        else if (ce_in) rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    logic s1_reg, s2_reg, s3_reg, line_reg, line_prev_reg;

    // three stages; change accepted only when 2nd and 3rd agree
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            line_reg <= 1'b1;
            line_prev_reg <= 1'b1;
        end else if (ce_in) begin
            s1_reg <= line_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) line_reg <= s3_reg;
            line_prev_reg <= line_reg;
        end
    end

    // ****************************************************************
    // selector: start detect and pulse sampling
    // ****************************************************************
    fls_rx_state_t rx_reg, rx_next;
    logic [`FLS_TMR_W-1:0] rx_tmr_reg, rx_tmr_next;
    logic [2:0] bit_reg, bit_next;
    logic [4:0] shift_reg, shift_next;
    logic frame_err_reg, overrun_reg;
    logic fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [4:0] fifo_out_data;

    wire fall = line_prev_reg && !line_reg;
    wire rx_tick = (rx_tmr_reg == '0);
    wire [`FLS_TMR_W-1:0] unit_reload = unit_len_in - 1'b1;
    wire rx_push = (rx_reg == FLS_RX_PUSH);
    wire stop_bad = (rx_reg == FLS_RX_STOP) && rx_tick && !line_reg;
    wire lost = rx_push && fall; // start missed while buffer is full

    // framing; the stop sample re-arms, so either stop length works
    always_comb begin
        rx_next = rx_reg;
        rx_tmr_next = rx_tick ? rx_tmr_reg : rx_tmr_reg - 1'b1;
        bit_next = bit_reg;
        shift_next = shift_reg;
        case (rx_reg)
            FLS_RX_IDLE: begin
                if (fall) begin
                    rx_next = FLS_RX_START;
                    rx_tmr_next = sample_ofs_in;
                end
            end
            FLS_RX_START: begin
                if (rx_tick) begin
                    // a start that is no longer spacing is noise
                    rx_next = line_reg ? FLS_RX_IDLE : FLS_RX_DATA;
                    rx_tmr_next = unit_reload;
                    bit_next = 3'h0;
                end
            end
            FLS_RX_DATA: begin
                if (rx_tick) begin
                    shift_next = {line_reg, shift_reg[4:1]};
                    rx_tmr_next = unit_reload;
                    bit_next = bit_reg + 3'h1;
                    if (bit_reg == 3'h4) rx_next = FLS_RX_STOP;
                end
            end
            FLS_RX_STOP: begin
                if (rx_tick) rx_next = FLS_RX_PUSH;
            end
            FLS_RX_PUSH: begin
                if (fifo_in_ready) rx_next = FLS_RX_IDLE;
            end
            default: rx_next = FLS_RX_IDLE;
        endcase
    end

    // selector registers
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_reg <= FLS_RX_IDLE;
            rx_tmr_reg <= '0;
            bit_reg <= 3'h0;
            shift_reg <= 5'h00;
        end else if (ce_in) begin
            rx_reg <= rx_next;
            rx_tmr_reg <= rx_tmr_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
        end
    end

    // sticky errors; a new error wins over a clear
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            frame_err_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else if (ce_in) begin
            frame_err_reg <= stop_bad || (frame_err_reg && !err_clear_in);
            overrun_reg <= lost || (overrun_reg && !err_clear_in);
        end
    end

    fls_fifo #(
        .WIDTH(`FLS_CODE_W),
        .DEPTH(`FLS_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .ce_in(ce_in),
        .in_valid_in(rx_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(shift_reg),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_out_data)
    );

    // ****************************************************************
    // stage sequencer
    // ****************************************************************
    fls_seq_state_t sq_reg, sq_next;
    logic [`FLS_TMR_W-1:0] sq_tmr_reg, sq_tmr_next;
    logic [4:0] code_reg;
    logic figs_reg;
    logic [`FLS_COL_W-1:0] col_reg;
    logic lf_left_reg;
    logic [`FLS_FN_W-1:0] func_reg;
    logic print_reg, blank_reg, space_reg, lf_reg;
    logic [5:0] char_reg;

    wire sq_tick = (sq_tmr_reg == '0);
    wire is_func = fls_is_func(code_reg);
    wire is_lf = (code_reg == `FLS_CODE_LF);
    wire at_end = (col_reg == `FLS_LAST_COL);
    wire may_space = (!is_func || code_reg == `FLS_CODE_SPACE) &&
        !at_end;
    assign fifo_pop = (sq_reg == FLS_SQ_IDLE) && fifo_out_valid;

    // stage order and lengths
    always_comb begin
        sq_next = sq_reg;
        sq_tmr_next = sq_tick ? sq_tmr_reg : sq_tmr_reg - 1'b1;
        case (sq_reg)
            FLS_SQ_IDLE: begin
                if (fifo_out_valid) begin
                    sq_next = FLS_SQ_CODEBAR;
                    sq_tmr_next = REV_LAST;
                end
            end
            FLS_SQ_CODEBAR: begin
                if (sq_tick) begin
                    sq_next = FLS_SQ_FUNC;
                    sq_tmr_next = REV_LAST;
                end
            end
            FLS_SQ_FUNC: begin
                if (sq_tick) begin
                    sq_next = FLS_SQ_PRINT;
                    sq_tmr_next = REV_LAST;
                end
            end
            FLS_SQ_PRINT: begin
                if (sq_tick) begin
                    sq_tmr_next = THIRD_LAST;
                    if (may_space) sq_next = FLS_SQ_SPACE;
                    else if (is_lf) sq_next = FLS_SQ_LF;
                    else sq_next = FLS_SQ_IDLE;
                end
            end
            FLS_SQ_SPACE: begin
                if (sq_tick) begin
                    sq_tmr_next = THIRD_LAST;
                    sq_next = is_lf ? FLS_SQ_LF : FLS_SQ_IDLE;
                end
            end
            FLS_SQ_LF: begin
                if (sq_tick) begin
                    sq_tmr_next = THIRD_LAST;
                    // second third-turn only for double feed
                    sq_next = lf_left_reg ? FLS_SQ_LF : FLS_SQ_IDLE;
                end
            end
            default: sq_next = FLS_SQ_IDLE;
        endcase
    end

    // stage state, code bars and case
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sq_reg <= FLS_SQ_IDLE;
            sq_tmr_reg <= '0;
            code_reg <= 5'h00;
            figs_reg <= `FLS_CASE_RESET;
            lf_left_reg <= 1'b0;
        end else if (ce_in) begin
            sq_reg <= sq_next;
            sq_tmr_reg <= sq_tmr_next;
            if (fifo_pop) code_reg <= fifo_out_data;
            if (fifo_pop) lf_left_reg <= double_lf_in;
            if (sq_reg == FLS_SQ_LF && sq_tick) lf_left_reg <= 1'b0;
            if (sq_reg == FLS_SQ_FUNC && sq_tick) begin
                if (code_reg == `FLS_CODE_LETTERS) figs_reg <= 1'b0;
                if (code_reg == `FLS_CODE_FIGURES) figs_reg <= 1'b1;
            end
        end
    end

    // stage results: one-cycle pulses at the end of the function, print, space and feed stages; blank, char and column are held
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            col_reg <= '0;
            func_reg <= '0;
            print_reg <= 1'b0;
            blank_reg <= 1'b0;
            char_reg <= 6'h00;
            space_reg <= 1'b0;
            lf_reg <= 1'b0;
        end else if (ce_in) begin
            func_reg <= '0;
            print_reg <= 1'b0;
            space_reg <= 1'b0;
            lf_reg <= 1'b0;
            if (sq_reg == FLS_SQ_FUNC && sq_tick) begin
                func_reg[`FLS_FN_LETTERS] <=
                    (code_reg == `FLS_CODE_LETTERS);
                func_reg[`FLS_FN_FIGURES] <=
                    (code_reg == `FLS_CODE_FIGURES);
                func_reg[`FLS_FN_CR] <= (code_reg == `FLS_CODE_CR);
                func_reg[`FLS_FN_LF] <= is_lf;
                func_reg[`FLS_FN_BLANK] <= (code_reg == `FLS_CODE_BLANK);
                if (code_reg == `FLS_CODE_CR) col_reg <= '0;
            end
            if (sq_reg == FLS_SQ_PRINT && sq_tick) begin
                print_reg <= 1'b1;
                blank_reg <= is_func;
                char_reg <= {figs_reg, code_reg};
            end
            if (sq_reg == FLS_SQ_SPACE && sq_tick) begin
                space_reg <= 1'b1;
                col_reg <= col_reg + 1'b1;
            end
            if (sq_reg == FLS_SQ_LF && sq_tick) lf_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign stage_out = sq_reg;
    assign code_bar_out = code_reg;
    assign figs_case_out = figs_reg;
    assign func_out = func_reg;
    assign print_out = print_reg;
    assign blank_out = blank_reg;
    assign char_out = char_reg;
    assign space_step_out = space_reg;
    assign lf_step_out = lf_reg;
    assign column_out = col_reg;
    assign frame_err_out = frame_err_reg;
    assign overrun_out = overrun_reg;
endmodule : fls_decoder

// File: logic/fls_regs.svh
// constants for the five-level shift decoder
`ifndef FLS_REGS_SVH
`define FLS_REGS_SVH

// ********************************************************************
// code layout: pulse one is bit 0, marking is 1
// ********************************************************************
`define FLS_CODE_W 5
`define FLS_CODE_LETTERS 5'h1f
`define FLS_CODE_FIGURES 5'h1b
`define FLS_CODE_CR 5'h08
`define FLS_CODE_LF 5'h02
`define FLS_CODE_SPACE 5'h04
`define FLS_CODE_BLANK 5'h00

// ********************************************************************
// function output bit positions
// ********************************************************************
`define FLS_FN_LETTERS 0
`define FLS_FN_FIGURES 1
`define FLS_FN_CR 2
`define FLS_FN_LF 3
`define FLS_FN_BLANK 4
`define FLS_FN_W 5

// ********************************************************************
// reset values and print line
// ********************************************************************
`define FLS_CASE_RESET 1'b0
`define FLS_COL_W 7
`define FLS_LAST_COL 7'h47
`define FLS_TMR_W 16
`define FLS_FIFO_DEPTH 8

`endif

// File: logic/fls_pkg.sv
// types shared by the five-level shift decoder
package fls_pkg;
    // receive framing states
    typedef enum logic [2:0] {
        FLS_RX_IDLE, FLS_RX_START, FLS_RX_DATA, FLS_RX_STOP, FLS_RX_PUSH
    } fls_rx_state_t;
    // operating stages, in trigger order
    typedef enum logic [2:0] {
        FLS_SQ_IDLE, FLS_SQ_CODEBAR, FLS_SQ_FUNC, FLS_SQ_PRINT,
        FLS_SQ_SPACE, FLS_SQ_LF
    } fls_seq_state_t;
endpackage : fls_pkg

// File: testbench/fls_decoder_sva.sv
// port assertions for the five-level shift decoder
`include "fls_regs.svh"
module fls_decoder_sva
    import fls_pkg::*;
#(
    parameter int REV_CYCLES = 12000
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // watched ports
    input wire logic double_lf_in,
    input wire fls_pkg::fls_seq_state_t stage_out,
    input wire logic [4:0] code_bar_out,
    input wire logic figs_case_out,
    input wire logic [4:0] func_out,
    input wire logic print_out,
    input wire logic blank_out,
    input wire logic space_step_out,
    input wire logic lf_step_out,
    input wire logic [6:0] column_out,
    input wire logic overrun_out
);
    localparam int PR_MAX = REV_CYCLES + 10;
    fls_seq_state_t prev_stage;
    logic [15:0] run_len;
    logic order_ok, full_ok, third_ok;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    // ********
    // helper logic
    // ********
    // length of the stage just left, read at the hand-over
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prev_stage <= FLS_SQ_IDLE;
            run_len <= 16'h0;
        end else begin
            prev_stage <= stage_out;
            run_len <= (stage_out != prev_stage) ? 16'h1 : run_len + 16'h1;
        end
    end
    // legal hand-overs; one cycle of slack on each stage length
    assign order_ok =
        (prev_stage == FLS_SQ_IDLE && stage_out == FLS_SQ_CODEBAR) ||
        (prev_stage == FLS_SQ_CODEBAR && stage_out == FLS_SQ_FUNC) ||
        (prev_stage == FLS_SQ_FUNC && stage_out == FLS_SQ_PRINT) ||
        (prev_stage == FLS_SQ_PRINT &&
         stage_out inside {FLS_SQ_SPACE, FLS_SQ_LF, FLS_SQ_IDLE}) ||
        (prev_stage == FLS_SQ_SPACE &&
         stage_out inside {FLS_SQ_LF, FLS_SQ_IDLE}) ||
        (prev_stage == FLS_SQ_LF && stage_out == FLS_SQ_IDLE);
    assign full_ok = run_len >= 16'(REV_CYCLES - 1) &&
        run_len <= 16'(REV_CYCLES + 1);
    assign third_ok = run_len >= 16'(REV_CYCLES / 3 - 1) &&
        run_len <= 16'(REV_CYCLES / 3 + 1);

    // ********
    // assertions
    // ********
    stage_order_a: assert property (
        stage_out != prev_stage |-> order_ok)
        else $error("illegal stage hand-over");
    full_stage_a: assert property (
        stage_out != prev_stage && prev_stage inside
        {FLS_SQ_CODEBAR, FLS_SQ_FUNC, FLS_SQ_PRINT} |-> full_ok)
        else $error("full stage length wrong");
    space_third_a: assert property (
        stage_out != prev_stage && prev_stage == FLS_SQ_SPACE |-> third_ok)
        else $error("spacing stage length wrong");
    func_onehot_a: assert property ($onehot0(func_out))
        else $error("more than one function output");
    func_blank_a: assert property (
        func_out != 5'h0 |-> ##[1:PR_MAX] (print_out && blank_out))
        else $error("function code without blank print");
    col_step_a: assert property (
        $rose(space_step_out) |-> column_out == $past(column_out) + 7'h1)
        else $error("column did not step by one");
    line_end_a: assert property (
        space_step_out |-> $past(column_out) != `FLS_LAST_COL)
        else $error("spacing past line end");
    lf_code_a: assert property (
        lf_step_out |-> code_bar_out == `FLS_CODE_LF)
        else $error("line feed on other code");
    case_shift_a: assert property (
        $changed(figs_case_out) |-> code_bar_out ==
        (figs_case_out ? `FLS_CODE_FIGURES : `FLS_CODE_LETTERS))
        else $error("case changed without shift code");
    cr_home_a: assert property (
        func_out[`FLS_FN_CR] |-> ##[0:1] column_out == 7'h0)
        else $error("return left column set");

    // main scenarios reached
    figs_print_c: cover property (print_out && figs_case_out);
    double_lf_c: cover property (lf_step_out && double_lf_in);
    overrun_c: cover property ($rose(overrun_out));
endmodule : fls_decoder_sva

bind fls_decoder fls_decoder_sva #(.REV_CYCLES(REV_CYCLES)) u_sva (
    .clk_in(clk_in), .resetn_in(resetn_in), .double_lf_in(double_lf_in),
    .stage_out(stage_out), .code_bar_out(code_bar_out),
    .figs_case_out(figs_case_out), .func_out(func_out),
    .print_out(print_out), .blank_out(blank_out),
    .space_step_out(space_step_out), .lf_step_out(lf_step_out),
    .column_out(column_out), .overrun_out(overrun_out));

// File: testbench/fls_tx_model.sv
// remote start-stop transmitter driving the signal line
module fls_tx_model (
    // clock
    input wire logic clk_in,
    // signal line, 1 = current flowing
    output logic line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // line idles marking between combinations
    initial line_out = 1'b1;
    // hold a level for n cycles, then step just past the edge
    task automatic hold(input logic lvl, input int n);
        line_out = lvl;
        repeat (n) @(posedge clk_in);
        #1;
    endtask : hold
    // spacing start, five pulses low bit first, stop of 1.0 or 1.42
    task automatic send(input logic [4:0] code, input int unit,
        input bit long_stop, input bit bad_stop);
        @(posedge clk_in);
        #1;
        hold(1'b0, unit);
        for (int i = 0; i < 5; i++) begin
            hold(code[i], unit);
        end
        hold(~bad_stop, long_stop ? unit + unit * 42 / 100 : unit);
        hold(1'b1, bad_stop ? unit : 0);
    endtask : send
    // short spacing blip, too short to reach the start sample
    task automatic glitch(input int n);
        @(posedge clk_in);
        #1;
        hold(1'b0, n);
        line_out = 1'b1;
    endtask : glitch
endmodule : fls_tx_model

// File: testbench/tb_fls_decoder.sv
// self-checking bench for the five-level shift decoder
`include "fls_regs.svh"
module tb_fls_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    import fls_pkg::*;
    localparam int REV = 30;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic line_in;
    logic [15:0] unit_len_in = 16'h000a;
    logic [15:0] sample_ofs_in = 16'h0005;
    logic double_lf_in = 1'b0;
    logic err_clear_in = 1'b0;
    fls_seq_state_t stage_out;
    logic [4:0] code_bar_out, func_out;
    logic [5:0] char_out;
    logic [6:0] column_out, mcol = 7'h0;
    logic figs_case_out, print_out, blank_out, space_step_out, lf_step_out;
    logic frame_err_out, overrun_out, mcase = 1'b0, col_ok = 1'b1;
    logic [4:0] exp_q[$];
    logic [4:0] func_seen = 5'h0;
    int errors = 0, check_count = 0, sp_cnt = 0, lf_cnt = 0;
    int exp_sp = 0, exp_lf = 0;
    bit fresh = 1'b1, mdbl = 1'b0;

    always #4 clk_in = ~clk_in;

    fls_decoder #(.REV_CYCLES(REV)) DUT (.clk_in(clk_in),
        .resetn_in(resetn_in), .ce_in(1'b1), .line_in(line_in),
        .unit_len_in(unit_len_in), .sample_ofs_in(sample_ofs_in),
        .double_lf_in(double_lf_in), .err_clear_in(err_clear_in),
        .stage_out(stage_out), .code_bar_out(code_bar_out),
        .figs_case_out(figs_case_out), .func_out(func_out),
        .print_out(print_out), .blank_out(blank_out), .char_out(char_out),
        .space_step_out(space_step_out), .lf_step_out(lf_step_out),
        .column_out(column_out), .frame_err_out(frame_err_out),
        .overrun_out(overrun_out));
    fls_tx_model u_tx (.clk_in(clk_in), .line_out(line_in));

    // ********
    // expectations and compares
    // ********
    function automatic logic [4:0] exp_func(input logic [4:0] c);
        case (c)
            `FLS_CODE_LETTERS: return 5'h01;
            `FLS_CODE_FIGURES: return 5'h02;
            `FLS_CODE_CR: return 5'h04;
            `FLS_CODE_LF: return 5'h08;
            `FLS_CODE_BLANK: return 5'h10;
            default: return 5'h00;
        endcase
    endfunction : exp_func
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_flag
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // scoreboard at the falling edge, where outputs have settled
    always @(negedge clk_in) begin
        logic [4:0] c;
        if (func_out !== 5'h0) func_seen = func_out;
        if (space_step_out === 1'b1) sp_cnt++;
        if (lf_step_out === 1'b1) lf_cnt++;
        if (print_out === 1'b1 && exp_q.size() != 0) begin
            c = exp_q.pop_front();
            if (!fresh) begin
                chk_val(8'(sp_cnt), 8'(exp_sp));
                chk_val(8'(lf_cnt), 8'(exp_lf));
            end
            if (c == `FLS_CODE_LETTERS) mcase = 1'b0;
            if (c == `FLS_CODE_FIGURES) mcase = 1'b1;
            if (c == `FLS_CODE_CR) begin
                mcol = 7'h0;
                col_ok = 1'b1;
            end
            chk_val({2'b0, char_out}, {2'b0, mcase, c});
            chk_flag(figs_case_out, mcase);
            chk_flag(blank_out, exp_func(c) != 5'h0);
            chk_val({3'b0, func_seen}, {3'b0, exp_func(c)});
            if (col_ok) chk_val({1'b0, column_out}, {1'b0, mcol});
            exp_sp = (exp_func(c) == 5'h0 && mcol != `FLS_LAST_COL);
            exp_lf = (c == `FLS_CODE_LF) ? (mdbl ? 2 : 1) : 0;
            mcol = mcol + 7'(exp_sp);
            fresh = 1'b0;
        end else if (print_out === 1'b1) begin
            fresh = 1'b1;
        end
        if (print_out === 1'b1) begin
            sp_cnt = 0;
            lf_cnt = 0;
            func_seen = 5'h0;
        end
    end

    // ********
    // stimulus
    // ********
    // keep at most four codes in flight so the buffer never overflows
    task automatic send(input logic [4:0] c, input bit long_stop);
        while (exp_q.size() >= 4) @(posedge clk_in);
        exp_q.push_back(c);
        u_tx.send(c, int'(unit_len_in), long_stop, 1'b0);
    endtask : send
    // idle for 20 cycles in a row, since one idle cycle may split codes
    task automatic drain();
        int quiet;
        quiet = 0;
        while (quiet < 20) begin
            @(posedge clk_in);
            quiet = (exp_q.size() == 0 && stage_out === FLS_SQ_IDLE) ?
                quiet + 1 : 0;
        end
        #1;
    endtask : drain
    task automatic clear_err();
        err_clear_in = 1'b1;
        @(posedge clk_in);
        #1;
        err_clear_in = 1'b0;
        @(posedge clk_in);
        #1;
    endtask : clear_err

    initial begin
        logic [4:0] c;
        void'($urandom(32'h3af8));
        repeat (10) @(posedge clk_in);
        #1 resetn_in = 1'b1;
        repeat (8) @(posedge clk_in);
        u_tx.glitch(3);
        repeat (150) @(posedge clk_in);
        chk_val({5'h0, stage_out}, {5'h0, FLS_SQ_IDLE});
        // every code, starting in letters then in figures, single then double feed
        for (int k = 0; k < 2; k++) begin
            mdbl = k[0];
            double_lf_in = k[0];
            send(k[0] ? `FLS_CODE_FIGURES : `FLS_CODE_LETTERS, 1'b0);
            for (int i = 0; i < 32; i++) send(5'(i), k[0]);
            drain();
        end
        // random graphics past the line end, other timing
        unit_len_in = 16'h0006;
        sample_ofs_in = 16'h0003;
        send(`FLS_CODE_CR, 1'b0);
        for (int i = 0; i < 76; i++) begin
            c = 5'($urandom_range(31, 1));
            if (exp_func(c) != 5'h0) c = 5'h11;
            send(c, 1'($urandom));
        end
        drain();
        // back-to-back burst overruns the buffer
        col_ok = 1'b0;
        unit_len_in = 16'h0004;
        sample_ofs_in = 16'h0001;
        for (int i = 0; i < 18; i++) u_tx.send(5'h11, 4, 1'b0, 1'b0);
        chk_flag(overrun_out, 1'b1);
        clear_err();
        chk_flag(overrun_out, 1'b0);
        drain();
        send(`FLS_CODE_CR, 1'b0);
        send(5'h03, 1'b0);
        drain();
        // spacing stop pulse
        col_ok = 1'b0;
        u_tx.send(5'h11, 4, 1'b0, 1'b1);
        chk_flag(frame_err_out, 1'b1);
        clear_err();
        chk_flag(frame_err_out, 1'b0);
        drain();
        report_and_stop();
    end

    // cut a hang short, well past the expected run length
    initial begin
        repeat (80000) @(posedge clk_in);
        errors++;
        report_and_stop();
    end
endmodule : tb_fls_decoder
